// [common/alsp_pkg.sv]
/*
  shared constants and carrier types for the angle load strobe controller.
  assumes a single 20 MHz clock and a device with a 12-bit angle port.
*/
package alsp_pkg;
  // clock rate and angle word width
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int ANGLE_W = 12;

  // strobe high time, least 100 ns, rounded up to cycles
  localparam int unsigned STROBE_HIGH_NS = 100;
  localparam int unsigned STROBE_HIGH_CYC =
    (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // falling edge to next rising edge, least 2.73 us (2730 ns)
  localparam int unsigned STROBE_GAP_NS = 2730;
  localparam int unsigned STROBE_GAP_CYC =
    (STROBE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // longest busy time 2.5 us, used as a timeout when waiting for busy
  localparam int unsigned BUSY_MAX_NS = 2500;
  localparam int unsigned BUSY_MAX_CYC = BUSY_MAX_NS / CLK_PERIOD_NS;

  // angle data set-up before the strobe rising edge, 25 ns
  localparam int unsigned SETUP_NS = 25;
  localparam int unsigned SETUP_CYC =
    (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 8;

  // modes that shape the angle before it is sent
  typedef enum logic [1:0] {
    ALSP_MODE_FWD = 2'b00,
    ALSP_MODE_REV = 2'b01
  } alsp_mode_type;

  // user request to load one angle
  typedef struct packed {
    logic [ANGLE_W-1:0] angle;
    alsp_mode_type mode;
    logic [1:0] pole_shift;
  } alsp_req_type;

  // pins driven to the device
  typedef struct packed {
    logic strobe;
    logic [ANGLE_W-1:0] angle;
  } alsp_pins_type;
endpackage

// [logic/alsp_angle_shape.sv]
/*
  angle shaping: pole-pair scaling by left shift and optional negation.
  assumes it is clocked with the controller; result is registered.
*/
module alsp_angle_shape
  import alsp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // request in
  input wire logic load,
  input wire alsp_req_type req,
  // shaped angle out
  output logic [ANGLE_W-1:0] angle_out
);
  logic [ANGLE_W-1:0] scaled;
  logic [ANGLE_W-1:0] shaped;

  // shift drops upper bits; negation wraps modulo 4096
  always_comb begin
    scaled = req.angle << req.pole_shift;
    if (req.mode == ALSP_MODE_REV) begin
      shaped = ANGLE_W'(~scaled + 1'b1);
    end else begin
      shaped = scaled;
    end
  end

  // hold the shaped word
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      angle_out <= '0;
    end else if (load) begin
      angle_out <= shaped;
    end
  end

  // reverse with one pole pair: word and result sum to zero mod 4096
  rev_wrap_a: assert property (
      @(posedge clock) disable iff (!rstn)
      load && req.mode == ALSP_MODE_REV && req.pole_shift == 2'b00 |=>
      ANGLE_W'(angle_out + $past(req.angle)) == '0)
    else $error("reverse angle not negated");

  // two pole pairs: one left shift, top bit dropped
  shift_one_a: assert property (
      @(posedge clock) disable iff (!rstn)
      load && req.mode == ALSP_MODE_FWD && req.pole_shift == 2'b01 |=>
      angle_out == {$past(req.angle[ANGLE_W-2:0]), 1'b0})
    else $error("pole shift wrong");
endmodule

// [logic/alsp_ctrl.sv]
/*
  controller that loads rotation angles into a vector rotation device.
  assumes the device busy pin is synchronous to clock.
  assumes the caller paces requests when stepping for harmonics.
*/
// Summary of operation
// - strobe high at least 100 ns
// - 2.73 us from strobe fall to rise
// - reverse rotation by presenting negated angle
// - harmonic n: step rate 4096*n*f (the controller steps once per request; the caller sets the rate)
// - scale angle by two to pole pairs-1
// - scale by left shift, dropping upper bits
module alsp_ctrl
  import alsp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // user request
  input wire logic req_valid,
  input wire alsp_req_type req,
  output logic req_ready,
  // completion
  output logic done,
  output logic timeout,
  // device pins
  output alsp_pins_type pins,
  input wire logic busy
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_HIGH = 3'b010,
    ST_WAIT = 3'b011,
    ST_GAP = 3'b100
  } alsp_state_type;

  alsp_state_type state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] gap_reg;
  logic [ANGLE_W-1:0] shaped;
  logic take;
  logic busy_seen_reg;

  assign take = (state_reg == ST_IDLE) && req_valid;

  // shaping stage registers the angle on acceptance
  alsp_angle_shape u_shape (
    .clock(clock),
    .rstn(rstn),
    .load(take),
    .req(req),
    .angle_out(shaped)
  );

  // handshake sequencer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          // one angle step per request; the caller sets the step rate
          if (req_valid) begin
            state_reg <= ST_SETUP;
            cnt_reg <= '0;
          end
        end
        ST_SETUP: begin
          // data stable before strobe rises
          if (cnt_reg >= CNT_W'(SETUP_CYC - 1)) begin
            state_reg <= ST_HIGH;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_HIGH: begin
          if (cnt_reg >= CNT_W'(STROBE_HIGH_CYC - 1)) begin
            state_reg <= ST_WAIT;
            cnt_reg <= '0;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_WAIT: begin
          // wait for busy to fall, bounded by its longest time
          if ((busy_seen_reg && !busy) ||
              cnt_reg >= CNT_W'(BUSY_MAX_CYC + 2)) begin
            state_reg <= ST_GAP;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        ST_GAP: begin
          if (gap_reg >= CNT_W'(STROBE_GAP_CYC - 1)) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // spacing from strobe fall to the next rise
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gap_reg <= '0;
    end else if (state_reg == ST_HIGH) begin
      gap_reg <= '0;
    end else if (gap_reg != '1) begin
      gap_reg <= gap_reg + 1'b1;
    end
  end

  // remember busy rising after the strobe fell
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_seen_reg <= 1'b0;
    end else if (state_reg != ST_WAIT) begin
      busy_seen_reg <= 1'b0;
    end else if (busy) begin
      busy_seen_reg <= 1'b1;
    end
  end

  // device pins, all registered
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pins <= '0;
    end else begin
      // strobe rises one cycle after the angle word, so data is set up
      pins.strobe <= (state_reg == ST_HIGH);
      if (state_reg == ST_SETUP) begin
        pins.angle <= shaped;
      end
    end
  end

  // user side status
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      req_ready <= 1'b0;
      done <= 1'b0;
      timeout <= 1'b0;
    end else begin
      req_ready <= (state_reg == ST_IDLE) && !req_valid;
      done <= (state_reg == ST_WAIT) && busy_seen_reg && !busy;
      timeout <= (state_reg == ST_WAIT) && !(busy_seen_reg && !busy) &&
                 cnt_reg >= CNT_W'(BUSY_MAX_CYC + 2);
    end
  end

  // strobe high time is at least the minimum
  property strobe_width_p;
    @(posedge clock) disable iff (!rstn)
      $rose(pins.strobe) |-> pins.strobe [*2];
  endproperty
  strobe_width_a: assert property (strobe_width_p)
    else $error("strobe pulse too short");

  // no new rise within the first 8 cycles after a fall
  sequence strobe_fall_s;
    $fell(pins.strobe);
  endsequence
  strobe_gap_a: assert property (@(posedge clock) disable iff (!rstn)
      strobe_fall_s |-> !pins.strobe [*8] ##0 (1'b1))
    else $error("strobe rose too soon");

  // angle stable while strobe high
  angle_stable_a: assert property (@(posedge clock) disable iff (!rstn)
      pins.strobe |-> $stable(pins.angle))
    else $error("angle changed under strobe");

  // angle already settled when the strobe rises
  strobe_setup_a: assert property (
      @(posedge clock) disable iff (!rstn)
      $rose(pins.strobe) |-> $stable(pins.angle))
    else $error("angle changed at strobe rise");

  // cycles since strobe was last high, for the full spacing check;
  // starts saturated so the first pulse after reset is legal
  logic [CNT_W-1:0] since_fall_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      since_fall_reg <= '1;
    end else if (pins.strobe) begin
      since_fall_reg <= '0;
    end else if (since_fall_reg != '1) begin
      since_fall_reg <= since_fall_reg + 1'b1;
    end
  end

  // full fall to rise spacing, not just the first cycles
  gap_count_a: assert property (
      @(posedge clock) disable iff (!rstn)
      $rose(pins.strobe) |-> since_fall_reg >= CNT_W'(STROBE_GAP_CYC))
    else $error("strobe spacing too short");

  // a taken request gives one strobe pulse of the set width
  sequence strobe_pulse_s;
    !pins.strobe ##1 pins.strobe [*2] ##1 !pins.strobe;
  endsequence
  load_pulse_a: assert property (
      @(posedge clock) disable iff (!rstn)
      take |-> ##2 strobe_pulse_s)
    else $error("no strobe pulse after request");

  // no strobe while idle and ready
  ready_idle_a: assert property (
      @(posedge clock) disable iff (!rstn)
      req_ready |-> !pins.strobe)
    else $error("strobe while ready");

  // completion is a single cycle pulse
  done_once_a: assert property (
      @(posedge clock) disable iff (!rstn)
      done |=> !done)
    else $error("done longer than one cycle");

  // timeout is a single cycle pulse
  timeout_once_a: assert property (
      @(posedge clock) disable iff (!rstn)
      timeout |=> !timeout)
    else $error("timeout longer than one cycle");
endmodule

// [testbench/alsp_ctrl_tb.sv]
/*
  self-checking bench for the angle load controller.
  assumes the device model answers with a chosen busy length.
*/
module alsp_ctrl_tb;
  import alsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  alsp_req_type req = '0;
  logic req_ready, done, timeout, busy;
  alsp_pins_type pins;
  logic [7:0] blen = 8'h28;
  logic [ANGLE_W-1:0] dev_angle;
  int n_fail = 0;
  int checked = 0;
  int gap = STROBE_GAP_CYC;
  int hi = 0;
  logic prev = 1'b0;

  alsp_ctrl i_alsp_ctrl (.clock(clock), .rstn(rstn), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .done(done), .timeout(timeout),
    .pins(pins), .busy(busy));
  alsp_dev_model i_alsp_dev_model (.clock(clock), .rstn(rstn), .pins(pins),
    .busy_len(blen), .busy(busy), .angle_reg(dev_angle));

  // clock and watchdog
  initial forever #25 clock = ~clock;
  initial begin
    #2ms;
    n_fail++;
    test_done();
  end

  task automatic check(input logic [ANGLE_W-1:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("fails %0d checks %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [ANGLE_W-1:0] shape(alsp_req_type r);
    logic [ANGLE_W-1:0] v;
    v = r.angle << r.pole_shift;
    return (r.mode == ALSP_MODE_REV) ? -v : v;
  endfunction

  // strobe width and spacing seen on the pins
  always @(negedge clock) begin
    gap++;
    if (pins.strobe) hi++;
    if (pins.strobe && !prev) check(gap >= STROBE_GAP_CYC, 1);
    if (!pins.strobe && prev) begin
      check(hi >= STROBE_HIGH_CYC, 1);
      gap = 0;
      hi = 0;
    end
    prev = pins.strobe;
  end

  // one load, then wait for done or timeout
  task automatic load(input alsp_req_type r, input logic [7:0] bl);
    int i;
    blen = bl;
    for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(negedge clock);
    check(req_ready, 1);
    req = r;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    for (i = 0; i < 300 && done !== 1'b1 && timeout !== 1'b1; i++)
      @(negedge clock);
    check(timeout, bl > 8'(BUSY_MAX_CYC));
    if (bl <= 8'(BUSY_MAX_CYC)) begin
      check(done, 1);
      check(busy, 0);
      check(dev_angle, shape(r));
      check(pins.angle, shape(r));
    end
    for (i = 0; i < 300 && busy !== 1'b0; i++) @(negedge clock);
  endtask

  // corner cases, then random loads back to back
  initial begin
    void'($urandom(92490));
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    load('{12'hFFF, ALSP_MODE_REV, 2'h3}, 8'd34);
    load('{12'h000, ALSP_MODE_REV, 2'h0}, 8'd50);
    load('{12'h801, ALSP_MODE_FWD, 2'h1}, 8'd60);
    load('{12'h123, ALSP_MODE_FWD, 2'h2}, 8'd40);
    repeat (20)
      load('{12'($urandom), alsp_mode_type'($urandom_range(0, 1)),
        2'($urandom)}, 8'($urandom_range(34, 50)));
    test_done();
  end
endmodule

// [testbench/alsp_dev_model.sv]
/*
  behavioural model of the rotation device angle port.
  assumes busy is made synchronous to the controller clock.
*/
module alsp_dev_model
  import alsp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // pins from the controller, busy length chosen by the bench
  input wire alsp_pins_type pins,
  input wire logic [7:0] busy_len,
  // device side
  output logic busy,
  output logic [ANGLE_W-1:0] angle_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic strobe_reg;
  logic [7:0] cnt_reg;

  // latch angle on strobe rise, busy pulse from strobe fall
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strobe_reg <= 1'b0;
      cnt_reg <= 8'h00;
      busy <= 1'b0;
      angle_reg <= '0;
    end else begin
      strobe_reg <= pins.strobe;
      if (pins.strobe && !strobe_reg)
        angle_reg <= pins.angle;
      if (!pins.strobe && strobe_reg) begin
        busy <= 1'b1;
        cnt_reg <= busy_len;
      end else if (cnt_reg > 8'h01) begin
        cnt_reg <= cnt_reg - 8'h01;
      end else begin
        busy <= 1'b0;
        cnt_reg <= 8'h00;
      end
    end
  end
endmodule
